// >>> tcu_pkg.sv
// Purpose: shared constants and types for the 8-bit timer/compare unit
// Assumes: one aligned 32-bit word per register on AHB-Lite
// Notes: offsets are byte addresses
package tcu_pkg;
  localparam logic [7:0] TCU_BOTTOM = 8'h00;
  localparam logic [7:0] TCU_MAX = 8'hff;
  // register byte offsets
  localparam logic [7:0] TCU_OFF_CTRL = 8'h00;
  localparam logic [7:0] TCU_OFF_CNT = 8'h04;
  localparam logic [7:0] TCU_OFF_CMP = 8'h08;
  localparam logic [7:0] TCU_OFF_FLAG = 8'h0c;
  localparam logic [7:0] TCU_OFF_MASK = 8'h10;
  localparam logic [7:0] TCU_OFF_PORT = 8'h14;
  // control register fields
  localparam int TCU_CTRL_CS_LSB = 0;
  localparam int TCU_CTRL_WGM_LSB = 3;
  localparam int TCU_CTRL_COM_LSB = 5;
  localparam int TCU_CTRL_FOC_BIT = 7;
  localparam int TCU_CTRL_AS_BIT = 8;
  // flag and mask fields
  localparam int TCU_FLAG_OVF_BIT = 0;
  localparam int TCU_FLAG_CMP_BIT = 1;
  // port register fields
  localparam int TCU_PORT_OUT_BIT = 0;
  localparam int TCU_PORT_DIR_BIT = 1;
  localparam logic [2:0] TCU_CS_STOP = 3'h0;
  localparam logic [1:0] TCU_COM_NONE = 2'h0;
  localparam logic [1:0] TCU_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TCU_COM_CLEAR = 2'h2;
  localparam logic [1:0] TCU_COM_SET = 2'h3;

  typedef enum logic [1:0] {
    TCU_WGM_NORMAL = 2'h0,
    TCU_WGM_FAST = 2'h1,
    TCU_WGM_CTC = 2'h2,
    TCU_WGM_PHASE = 2'h3
  } tcu_wgm_e;

  typedef enum logic {
    TCU_DIR_UP,
    TCU_DIR_DOWN
  } tcu_dir_e;

  typedef struct packed {
    logic [7:0] haddr;
    logic hwrite;
    logic sel;
  } tcu_ahb_req_s;
endpackage

// >>> tcu_tick_gen.sv
// Purpose: timer clock enable from clock select and source
// Assumes: osc_tick already synchronous to hclk
// Notes: prescale taps are powers of two as a plain default
`timescale 1ns/1ps
module tcu_tick_gen
  import tcu_pkg::*;
#(
  parameter int PW = 10
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // selection
  input wire logic [2:0] clock_select,
  input wire logic async_clock_select,
  input wire logic osc_tick,
  // tick out
  output logic tick
);
  typedef struct packed {
    logic [PW-1:0] pre;
  } tcu_tick_s;
  tcu_tick_s s_q, s_d;
  logic base;
  logic [PW-1:0] mask;

  always_comb begin
    s_d = s_q;
    base = async_clock_select ? osc_tick : 1'b1;
    mask = '0;
    case (clock_select)
      3'h1: mask = '0;
      3'h2: mask = PW'(10'h007);
      3'h3: mask = PW'(10'h01f);
      3'h4: mask = PW'(10'h03f);
      3'h5: mask = PW'(10'h07f);
      3'h6: mask = PW'(10'h0ff);
      3'h7: mask = PW'(10'h3ff);
      default: mask = '0;
    endcase
    tick = 1'b0;
    if (clock_select != TCU_CS_STOP && base) begin
      s_d.pre = s_q.pre + PW'(1);
      tick = (s_q.pre & mask) == mask;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
endmodule

// >>> tcu_timer8.sv
// Purpose: 8-bit timer/counter with one compare channel on AHB-Lite
// Assumes: single-word transfers, zero wait states, OKAY always
// Notes: no interrupt logic; irq request levels are outputs
// How it works
// - zero is bottom; bottom indication when count becomes zero
// - 0xff is max; max indication when counter reaches it
// - top is 0xff or compare value depending on waveform mode
// - timer clock from io clock, or oscillator when async select set
// - clear, count up or down per tick; stopped when clock select zero
// - cpu may read and write the count at any time
// - cpu count write beats clear or count in the same cycle
// - counting sequence chosen by two waveform mode bits
// - overflow flag set per mode and can request an interrupt
// - equality sets compare flag on the following tick
// - compare interrupt requested when flag set and enable one
// - compare flag cleared on service or by writing one
// - pwm modes buffer compare value, update at top
// - cpu accesses buffer when buffering, else active compare register
// - force strobe acts like a match in non-pwm modes, no flag
// - count write blocks compare match in the next tick
// - compare output state kept across waveform mode changes
// - output mode not buffered; applies at the next match
// - nonzero output mode overrides port value; direction from port register
// - output mode zero leaves compare output unchanged on match
// - mode 0 normal, 1 fast pwm, 2 ctc, 3 phase pwm
`timescale 1ns/1ps
module tcu_timer8
  import tcu_pkg::*;
#(
  parameter int PRESCALE_W = 10
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // oscillator tick, synchronous to hclk
  input wire logic osc_tick,
  // interrupt acknowledges
  input wire logic ovf_irq_ack,
  input wire logic cmp_irq_ack,
  // interrupt requests
  output logic ovf_irq,
  output logic cmp_irq,
  // compare pin
  output logic pin_out,
  output logic pin_oe,
  // count range markers
  output logic at_bottom,
  output logic at_max
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    tcu_ahb_req_s req;
    logic [31:0] rdata;
    logic [7:0] cnt;
    logic [7:0] cmp_act;
    logic [7:0] cmp_buf;
    logic [2:0] clock_select;
    tcu_wgm_e waveform_mode;
    logic [1:0] compare_output_mode;
    logic async_clock_select;
    logic overflow_flag;
    logic compare_match_flag;
    logic overflow_irq_enable;
    logic compare_irq_enable;
    logic compare_output;
    logic port_value;
    logic pin_direction;
    tcu_dir_e dir;
    logic block_pend;
    logic match_pend;
  } tcu_state_s;

  tcu_state_s s_q, s_d;
  logic tick;
  logic is_pwm;
  logic [7:0] top;
  logic match;
  logic wr_hit;
  logic cnt_wr;
  logic [31:0] wd;
  logic force_now;
  logic match_act;
  logic at_top_tick;
  logic ovf_set;

  tcu_tick_gen #(
    .PW(PRESCALE_W)
  ) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .clock_select(s_q.clock_select),
    .async_clock_select(s_q.async_clock_select),
    .osc_tick(osc_tick),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // comparator and markers
  always_comb begin
    is_pwm = (s_q.waveform_mode == TCU_WGM_FAST) || (s_q.waveform_mode == TCU_WGM_PHASE);
    top = (s_q.waveform_mode == TCU_WGM_CTC) ? s_q.cmp_act : TCU_MAX;
    match = (s_q.cnt == s_q.cmp_act);
    at_bottom = (s_q.cnt == TCU_BOTTOM);
    at_max = (s_q.cnt == TCU_MAX);
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    wd = hwdata;
    wr_hit = s_q.req.sel && s_q.req.hwrite;
    cnt_wr = wr_hit && (s_q.req.haddr == TCU_OFF_CNT);
    force_now = 1'b0;
    match_act = 1'b0;
    at_top_tick = 1'b0;
    ovf_set = 1'b0;

    // address phase capture; zero wait states
    s_d.req.sel = hsel && hready && htrans[1];
    s_d.req.haddr = {haddr[7:2], 2'b00};
    s_d.req.hwrite = hwrite;

    // compare match seen on a tick takes effect on the next tick
    if (tick) begin
      // a block spans exactly the tick after the count write
      s_d.match_pend = match && !s_q.block_pend;
      s_d.block_pend = 1'b0;
      if (s_q.match_pend) begin
        s_d.compare_match_flag = 1'b1;
        match_act = 1'b1;
      end
      // counting sequence per mode
      case (s_q.waveform_mode)
        TCU_WGM_NORMAL: begin
          s_d.cnt = s_q.cnt + 8'h01;
          if (s_q.cnt == TCU_MAX) begin
            ovf_set = 1'b1;
          end
        end
        TCU_WGM_CTC: begin
          if (s_q.cnt == top) begin
            s_d.cnt = TCU_BOTTOM;
          end else begin
            s_d.cnt = s_q.cnt + 8'h01;
          end
          if (s_q.cnt == TCU_MAX) begin
            ovf_set = 1'b1;
          end
        end
        TCU_WGM_FAST: begin
          s_d.cnt = s_q.cnt + 8'h01;
          if (s_q.cnt == TCU_MAX) begin
            ovf_set = 1'b1;
            at_top_tick = 1'b1;
          end
        end
        TCU_WGM_PHASE: begin
          if (s_q.dir == TCU_DIR_UP) begin
            if (s_q.cnt == TCU_MAX) begin
              s_d.dir = TCU_DIR_DOWN;
              s_d.cnt = s_q.cnt - 8'h01;
              at_top_tick = 1'b1;
            end else begin
              s_d.cnt = s_q.cnt + 8'h01;
            end
          end else begin
            if (s_q.cnt == TCU_BOTTOM) begin
              s_d.dir = TCU_DIR_UP;
              s_d.cnt = s_q.cnt + 8'h01;
              ovf_set = 1'b1;
            end else begin
              s_d.cnt = s_q.cnt - 8'h01;
            end
          end
        end
        default: begin
          s_d.cnt = s_q.cnt;
        end
      endcase
      // the event itself, not the old flag level, decides set-beats-clear
      if (ovf_set) begin
        s_d.overflow_flag = 1'b1;
      end
      if (!is_pwm) begin
        s_d.dir = TCU_DIR_UP;
      end
      // buffered compare value loads at top in pwm modes
      if (is_pwm && at_top_tick) begin
        s_d.cmp_act = s_q.cmp_buf;
      end
    end

    // acknowledges from interrupt service
    if (ovf_irq_ack && !ovf_set) begin
      s_d.overflow_flag = 1'b0;
    end
    if (cmp_irq_ack && !match_act) s_d.compare_match_flag = 1'b0;

    // register writes, data phase
    if (wr_hit) begin
      case (s_q.req.haddr)
        TCU_OFF_CTRL: begin
          s_d.clock_select = wd[TCU_CTRL_CS_LSB +: 3];
          s_d.waveform_mode = tcu_wgm_e'(wd[TCU_CTRL_WGM_LSB +: 2]);
          s_d.compare_output_mode = wd[TCU_CTRL_COM_LSB +: 2];
          s_d.async_clock_select = wd[TCU_CTRL_AS_BIT];
          force_now = wd[TCU_CTRL_FOC_BIT] && (wd[TCU_CTRL_WGM_LSB] == 1'b0);
        end
        TCU_OFF_CNT: begin
          s_d.cnt = wd[7:0];
          s_d.block_pend = 1'b1;
          s_d.match_pend = 1'b0;
        end
        TCU_OFF_CMP: begin
          if (is_pwm) s_d.cmp_buf = wd[7:0];
          else begin
            s_d.cmp_act = wd[7:0];
            s_d.cmp_buf = wd[7:0];
          end
        end
        TCU_OFF_FLAG: begin
          // set wins over a write-one clear in the same cycle
          if (wd[TCU_FLAG_OVF_BIT] && !ovf_set) begin
            s_d.overflow_flag = 1'b0;
          end
          if (wd[TCU_FLAG_CMP_BIT] && !match_act) s_d.compare_match_flag = 1'b0;
        end
        TCU_OFF_MASK: begin
          s_d.overflow_irq_enable = wd[TCU_FLAG_OVF_BIT];
          s_d.compare_irq_enable = wd[TCU_FLAG_CMP_BIT];
        end
        TCU_OFF_PORT: begin
          s_d.port_value = wd[TCU_PORT_OUT_BIT];
          s_d.pin_direction = wd[TCU_PORT_DIR_BIT];
        end
        default: begin
        end
      endcase
    end

    // waveform generator; output mode read live, not buffered
    // a strobe written together with a new output mode acts on that new mode
    if (match_act || force_now) begin
      if (!is_pwm || force_now) begin
        case (s_d.compare_output_mode)
          TCU_COM_TOGGLE: s_d.compare_output = !s_q.compare_output;
          TCU_COM_CLEAR: s_d.compare_output = 1'b0;
          TCU_COM_SET: s_d.compare_output = 1'b1;
          default: s_d.compare_output = s_q.compare_output;
        endcase
      end else begin
        // pwm: mode 2 clears on match, mode 3 sets; phase mode flips when going down
        case (s_d.compare_output_mode)
          TCU_COM_CLEAR: s_d.compare_output = (s_q.waveform_mode == TCU_WGM_PHASE) && (s_q.dir == TCU_DIR_DOWN);
          TCU_COM_SET: s_d.compare_output = !((s_q.waveform_mode == TCU_WGM_PHASE) && (s_q.dir == TCU_DIR_DOWN));
          TCU_COM_TOGGLE: s_d.compare_output = !s_q.compare_output;
          default: s_d.compare_output = s_q.compare_output;
        endcase
      end
    end
    // fast pwm restores the level when the counter wraps to bottom
    if (tick && at_top_tick && s_q.waveform_mode == TCU_WGM_FAST && !match_act) begin
      if (s_d.compare_output_mode == TCU_COM_CLEAR) begin
        s_d.compare_output = 1'b1;
      end
      if (s_d.compare_output_mode == TCU_COM_SET) begin
        s_d.compare_output = 1'b0;
      end
    end

    // read data for the next data phase
    s_d.rdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case ({haddr[7:2], 2'b00})
        TCU_OFF_CTRL: begin
          s_d.rdata[TCU_CTRL_CS_LSB +: 3] = s_q.clock_select;
          s_d.rdata[TCU_CTRL_WGM_LSB +: 2] = s_q.waveform_mode;
          s_d.rdata[TCU_CTRL_COM_LSB +: 2] = s_q.compare_output_mode;
          s_d.rdata[TCU_CTRL_AS_BIT] = s_q.async_clock_select;
        end
        TCU_OFF_CNT: s_d.rdata[7:0] = s_q.cnt;
        TCU_OFF_CMP: s_d.rdata[7:0] = is_pwm ? s_q.cmp_buf : s_q.cmp_act;
        TCU_OFF_FLAG: begin
          s_d.rdata[TCU_FLAG_OVF_BIT] = s_q.overflow_flag;
          s_d.rdata[TCU_FLAG_CMP_BIT] = s_q.compare_match_flag;
        end
        TCU_OFF_MASK: begin
          s_d.rdata[TCU_FLAG_OVF_BIT] = s_q.overflow_irq_enable;
          s_d.rdata[TCU_FLAG_CMP_BIT] = s_q.compare_irq_enable;
        end
        TCU_OFF_PORT: begin
          s_d.rdata[TCU_PORT_OUT_BIT] = s_q.port_value;
          s_d.rdata[TCU_PORT_DIR_BIT] = s_q.pin_direction;
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    hrdata = s_q.rdata;
    hreadyout = 1'b1;
    hresp = 1'b0;
    ovf_irq = s_q.overflow_flag && s_q.overflow_irq_enable;
    cmp_irq = s_q.compare_match_flag && s_q.compare_irq_enable;
    pin_out = (s_q.compare_output_mode != TCU_COM_NONE) ? s_q.compare_output : s_q.port_value;
    pin_oe = s_q.pin_direction;
  end
endmodule

// >>> tcu_timer8_checker.sv
// Purpose: port-level assertions for tcu_timer8
// Assumes: zero wait bus, hready fed from hreadyout
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module tcu_timer8_checker
  import tcu_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // timer outputs
  input wire logic ovf_irq,
  input wire logic cmp_irq,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic at_bottom,
  input wire logic at_max
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic rd;
  logic dir_bit;
  assign take = ce && hsel && hready && htrans[1];
  assign rd = take && !hwrite;
  assign dir_bit = hwdata[TCU_PORT_DIR_BIT];
  ////////////////////////////////////////////////////////////////
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_range_excl: assert property (!(at_bottom && at_max))
    else $error("bottom and max both high");
  a_reset_clear: assert property ($rose(hresetn) |-> at_bottom && !ovf_irq && !cmp_irq && !pin_oe && !pin_out)
    else $error("outputs not cleared by reset");
  a_idle_rdata: assert property (ce && !rd |=> hrdata == 32'h0)
    else $error("read data not zero outside a read");
  a_ctrl_rd_zero: assert property (rd && haddr[7:0] == TCU_OFF_CTRL |=> !hrdata[TCU_CTRL_FOC_BIT] && hrdata[31:9] == 23'h0)
    else $error("force strobe or upper control bits read nonzero");
  a_cmp_irq_flag: assert property (rd && haddr[7:0] == TCU_OFF_FLAG && cmp_irq |=> hrdata[TCU_FLAG_CMP_BIT])
    else $error("compare request without compare flag");
  a_ovf_irq_flag: assert property (rd && haddr[7:0] == TCU_OFF_FLAG && ovf_irq |=> hrdata[TCU_FLAG_OVF_BIT])
    else $error("overflow request without overflow flag");
  a_ce_freeze: assert property (!ce |=> $stable(at_bottom) && $stable(at_max) && $stable(pin_out) && $stable(cmp_irq))
    else $error("state moved while clock enable low");
  a_dir_write: assert property (take && hwrite && haddr[7:0] == TCU_OFF_PORT ##1 ce |=> pin_oe == $past(dir_bit))
    else $error("pin direction not taken from port write");
  c_cmp: cover property ($rose(cmp_irq));
  c_ovf: cover property ($rose(ovf_irq));
  c_drive: cover property (pin_oe && pin_out);
endmodule
bind tcu_timer8 tcu_timer8_checker u_chk (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .hreadyout, .hresp, .ovf_irq, .cmp_irq, .pin_out, .pin_oe, .at_bottom, .at_max);

// >>> tcu_timer8_tb.sv
// Purpose: self-checking bench for tcu_timer8
// Assumes: zero wait slave, osc_tick pulses synchronous to hclk
// Notes: rows cover plain register access, hand tests cover the timer
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tcu_timer8_tb
  import tcu_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} tcu_row_s;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic osc_tick = 1'b0;
  logic ovf_irq_ack = 1'b0;
  logic cmp_irq_ack = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rv;
  logic hreadyout, hresp, ovf_irq, cmp_irq, pin_out, pin_oe, at_bottom, at_max;
  int n_mismatch = 0;
  int comparisons = 0;
  // force bit reads back zero; upper count bits dropped
  tcu_row_s rows [9] = '{'{8'h00, 32'h1f8, 32'h178}, '{8'h04, 32'h5a, 32'h5a}, '{8'h10, 32'h3, 32'h3},
    '{8'h14, 32'h1, 32'h1}, '{8'h18, 32'hffffffff, 32'h0}, '{8'hfc, 32'hffffffff, 32'h0},
    '{8'h00, 32'h0, 32'h0}, '{8'h08, 32'ha5, 32'ha5}, '{8'h04, 32'h1ff, 32'hff}};
  tcu_timer8 #(.PRESCALE_W(10)) uut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .osc_tick, .ovf_irq_ack, .cmp_irq_ack,
    .ovf_irq, .cmp_irq, .pin_out, .pin_oe, .at_bottom, .at_max);
  initial forever #25 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    // only the watchdog ends a wait for the slave
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
    rd(a, rv);
    `CHK(s, e, rv)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic pin(input logic e);
    cyc(1);
    `CHK("pin_out", e, pin_out)
  endtask
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    close_out;
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    `CHK("at_bottom", 1'b1, at_bottom)
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdc("row", rows[i].a, rows[i].e);
    end
    cyc(1);
    `CHK("at_max", 1'b1, at_max)
    `CHK("port", 1'b1, pin_out)
    cyc(8);
    rdc("stopped", 8'h04, 32'hff);
    // run from max, expect wrap to bottom with overflow
    wr(8'h00, 32'h1);
    for (int i = 0; i < 40 && at_bottom !== 1'b1; i++) @(posedge hclk);
    `CHK("wrap", 1'b1, ovf_irq)
    wr(8'h00, 32'h0);
    rdc("ovf_flag", 8'h0c, 32'h1);
    @(posedge hclk);
    ovf_irq_ack <= 1'b1;
    @(posedge hclk);
    ovf_irq_ack <= 1'b0;
    pin(1'b1);
    `CHK("ovf_ack", 1'b0, ovf_irq)
    // clear-on-compare with top 3
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h3);
    wr(8'h00, 32'h31);
    for (int i = 0; i < 40 && cmp_irq !== 1'b1; i++) @(posedge hclk);
    `CHK("match", 1'b1, cmp_irq)
    wr(8'h00, 32'h30);
    rd(8'h04, rv);
    `CHK("top", 1'b1, rv <= 32'h3)
    @(posedge hclk);
    cmp_irq_ack <= 1'b1;
    @(posedge hclk);
    cmp_irq_ack <= 1'b0;
    cyc(1);
    `CHK("cmp_ack", 1'b0, cmp_irq)
    // count write equal to compare loses that match
    wr(8'h08, 32'h40);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h40);
    cyc(6);
    rdc("blocked", 8'h0c, 32'h0);
    wr(8'h04, 32'h3e);
    cyc(6);
    rdc("hit", 8'h0c, 32'h2);
    // oscillator source: counts only on osc_tick
    wr(8'h00, 32'h101);
    wr(8'h04, 32'h20);
    cyc(6);
    rdc("osc_idle", 8'h04, 32'h20);
    @(posedge hclk);
    osc_tick <= 1'b1;
    @(posedge hclk);
    osc_tick <= 1'b0;
    rdc("osc_tick", 8'h04, 32'h21);
    // output unit with timer stopped
    wr(8'h00, 32'h0);
    wr(8'h0c, 32'h3);
    wr(8'h00, 32'he0);
    wr(8'h14, 32'h3);
    pin(1'b1);
    wr(8'h00, 32'hc0);
    pin(1'b0);
    wr(8'h00, 32'h80);
    pin(1'b1);
    wr(8'h00, 32'h30);
    pin(1'b0);
    wr(8'h00, 32'ha8);
    pin(1'b0);
    rdc("no_flag", 8'h0c, 32'h0);
    `CHK("pin_oe", 1'b1, pin_oe)
    // pwm writes land in the buffer only
    wr(8'h00, 32'h18);
    wr(8'h08, 32'h77);
    rdc("buffer", 8'h08, 32'h77);
    wr(8'h00, 32'h0);
    rdc("active", 8'h08, 32'h40);
    // fast pwm run across max pulls the buffered value into the active register
    wr(8'h00, 32'h08);
    wr(8'h04, 32'hfe);
    wr(8'h00, 32'h09);
    cyc(4);
    wr(8'h00, 32'h0);
    rdc("reload", 8'h08, 32'h77);
    wr(8'h00, 32'h1);
    ce <= 1'b0;
    cyc(4);
    ce <= 1'b1;
    hresetn <= 1'b0;
    cyc(2);
    hresetn <= 1'b1;
    cyc(1);
    `CHK("rst_oe", 1'b0, pin_oe)
    rdc("rst_ctrl", 8'h00, 32'h0);
    rdc("rst_cmp", 8'h08, 32'h0);
    rdc("rst_cnt", 8'h04, 32'h0);
    close_out;
  end
endmodule
